// [shared/mss_pkg.sv]
`default_nettype none

package mss_pkg;

    // ------------------------------------------------------------
    // control store geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 14;
    localparam int WORD_W = 80;
    localparam int DEPTH = 16384;
    localparam int STACK_DEPTH = 16;
    localparam logic [4:0] STACK_FULL = 5'h10;
    localparam logic [3:0] LAST_BYTE = 4'h9;

    // ------------------------------------------------------------
    // fixed addresses and reset values
    // ------------------------------------------------------------
    localparam logic [13:0] START_ADDR = 14'h0080;
    localparam logic [13:0] IDLE_ADDR = 14'h0040;
    localparam logic [13:0] BIT11_MASK = 14'h0020;
    localparam logic [13:0] BIT12_MASK = 14'h0010;
    localparam logic RST_CLEAR = 1'b1;
    localparam logic RST_REPEAT = 1'b1;

    // ------------------------------------------------------------
    // microword fields: control field bit n sits at word bit 49-n
    // ------------------------------------------------------------
    localparam int SEL_HI = 31;
    localparam int SEL_LO = 29;
    localparam int CTL12_HI = 48;
    localparam int CTL12_LO = 47;
    localparam int CTL14_LO = 45;
    localparam int CTL316_HI = 46;
    localparam int CTL316_LO = 33;

    // ------------------------------------------------------------
    // next-address operations
    // ------------------------------------------------------------
    localparam logic [2:0] OP_RETURN = 3'h0;
    localparam logic [2:0] OP_JUMP = 3'h1;
    localparam logic [2:0] OP_SPLIT = 3'h2;
    localparam logic [2:0] OP_FLIP = 3'h3;
    localparam logic [2:0] OP_COND_RETURN = 3'h4;
    localparam logic [2:0] OP_CALL_JUMP = 3'h5;
    localparam logic [2:0] OP_CALL_GOTO = 3'h6;
    localparam logic [2:0] OP_PUSH = 3'h7;
    localparam logic [1:0] SUB_DECODE = 2'h0;
    localparam logic [1:0] SUB_BUS_BRANCH = 2'h1;
    localparam logic [1:0] SUB_LOGICAL = 2'h2;
    localparam logic [1:0] SUB_GOTO = 2'h3;

    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_ADDR_HIGH = 8'h00;
    localparam logic [7:0] OFF_ADDR_LOW = 8'h04;
    localparam logic [7:0] OFF_DATA = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0c;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] LOAD_BEAT_CYCLES = 2'h2;

    // one beat is two clocks: address half, then memory-read half
    typedef enum logic [1:0] {
        PH_ADDR = 2'b01,
        PH_READ = 2'b10
    } mss_phase_type;

endpackage : mss_pkg

`default_nettype wire

// [logic/mss_sequencer.sv]
// Behaviour
// - 16K by 80-bit store, indexed by address
// - reads use same sequence with byte reads
// - no distinction between loading sources
// - select field and split code pick operation
// - address per stage5, word at late clock
// - clear holds address at octal 200
// - first power-on release repeats first word
// - return pops stack top as next address
// - empty-stack return signals return-to-fetch
// - idle request during fetch return gives idle step
// - stack write pulse half beat after stage5
// - jump: current high, control, conditions
// - decodes take address from decode network
// - bus branch loads halves at late clock
// - goto takes control field bits 3-16
// - flip step inverts address bit 12
// - conditional return pops or forms jump
// - call-jump pushes address with bit11 inverted
// - call-goto jumps like goto and pushes
// - push: flip bit12, push bit11-inverted
// - trap vectors low bits, pushes normal next
//
// Our own choices: the address map and the AXI4-Lite interface to the registers.
`default_nettype none

module mss_sequencer (
    // clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clock_enable,
    // axi4-lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data and response
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // system clear pin, active low
    input wire logic system_clear_n,
    // sequencing inputs
    input wire logic [3:0] jump_address_bits,
    input wire logic conditional_return_true,
    input wire logic [13:0] decode_address,
    input wire logic effective_address_select,
    input wire logic [3:0] effective_address_bits,
    input wire logic [7:0] data_bus_high,
    input wire logic bus_load_high,
    input wire logic bus_load_low,
    input wire logic idle_step_request,
    input wire logic trap_request,
    input wire logic trap_from_storage,
    input wire logic [3:0] trap_vector,
    // sequencing outputs
    output logic [79:0] control_word,
    output logic [13:0] microword_address,
    output logic stage5_address_clock,
    output logic late_control_word_clock,
    output logic stack_empty_flag,
    output logic return_to_fetch,
    output logic stack_write_pulse,
    output logic high_half_load_clock,
    output logic low_half_load_clock
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic clr_meta;
        logic clr_sync;
        mss_pkg::mss_phase_type phase;
        logic have_word;
        logic repeat_pending;
        logic [13:0] nar;
        logic [79:0] cword;
        logic [15:0][13:0] stack;
        logic [4:0] sp;
        logic rtf;
        logic swp;
        logic [1:0] hcnt;
        logic [1:0] lcnt;
        logic [13:0] load_addr;
        logic [3:0] byte_idx;
        logic [71:0] assembly;
        logic aw_held;
        logic [7:0] awaddr;
        logic w_held;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } mss_state_type;

    mss_state_type s;
    mss_state_type next_s;

    // flip-flop store; kept outside the struct so the per-cycle copy stays small
    logic [79:0] store [mss_pkg::DEPTH];

    logic mem_we;
    logic [79:0] mem_wdata;
    logic [79:0] rd_word;
    logic [7:0] rd_byte;
    logic stage5;
    logic seq_normal;
    logic [2:0] op;
    logic [1:0] sub;
    logic [13:0] jump_next;
    logic [13:0] goto_next;
    logic [13:0] dec_next;
    logic [13:0] seq_next;
    logic [13:0] push_val;
    logic [4:0] seq_sp;
    logic do_pop;
    logic do_push;

    assign op = s.cword[mss_pkg::SEL_HI:mss_pkg::SEL_LO];
    assign sub = s.cword[mss_pkg::CTL12_HI:mss_pkg::CTL12_LO];
    assign stage5 = clock_enable && !s.clr_sync && (s.phase == mss_pkg::PH_ADDR);
    assign seq_normal = s.have_word && !s.repeat_pending;
    assign rd_word = store[s.load_addr];
    assign rd_byte = rd_word[8 * (9 - int'(s.byte_idx)) +: 8];

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_s = s;
        mem_we = 1'b0;
        mem_wdata = {s.assembly, s.wdata[7:0]};
        do_pop = 1'b0;
        do_push = 1'b0;
        seq_sp = s.sp;
        jump_next = {s.nar[13:6], s.cword[mss_pkg::CTL12_HI:mss_pkg::CTL12_LO], jump_address_bits};
        goto_next = s.cword[mss_pkg::CTL316_HI:mss_pkg::CTL316_LO];
        dec_next = effective_address_select ? {decode_address[13:4], effective_address_bits}
                                            : decode_address;
        seq_next = s.nar;
        push_val = s.nar ^ mss_pkg::BIT11_MASK;

        // pin sync: first stage feeds only the second
        next_s.clr_meta = ~system_clear_n;
        next_s.clr_sync = s.clr_meta;
        next_s.rtf = 1'b0;
        next_s.swp = 1'b0;
        if (s.hcnt != 2'h0) begin
            next_s.hcnt = 2'(s.hcnt - 2'h1);
        end
        if (s.lcnt != 2'h0) begin
            next_s.lcnt = 2'(s.lcnt - 2'h1);
        end

        // operation select
        case (op)
            mss_pkg::OP_RETURN: begin
                do_pop = 1'b1;
            end
            mss_pkg::OP_JUMP: begin
                seq_next = jump_next;
            end
            mss_pkg::OP_SPLIT: begin
                case (sub)
                    mss_pkg::SUB_DECODE: seq_next = dec_next;
                    mss_pkg::SUB_LOGICAL: seq_next = dec_next;
                    mss_pkg::SUB_BUS_BRANCH: seq_next = s.nar;
                    default: seq_next = goto_next;
                endcase
            end
            mss_pkg::OP_FLIP: begin
                seq_next = s.nar ^ mss_pkg::BIT12_MASK;
            end
            mss_pkg::OP_COND_RETURN: begin
                if (conditional_return_true) begin
                    do_pop = 1'b1;
                end else begin
                    seq_next = {s.nar[13:6], s.cword[mss_pkg::CTL12_HI:mss_pkg::CTL14_LO],
                                jump_address_bits[1:0]};
                end
            end
            mss_pkg::OP_CALL_JUMP: begin
                seq_next = jump_next;
                do_push = 1'b1;
            end
            mss_pkg::OP_CALL_GOTO: begin
                seq_next = goto_next;
                do_push = 1'b1;
            end
            default: begin
                seq_next = s.nar ^ mss_pkg::BIT12_MASK;
                do_push = 1'b1;
            end
        endcase

        if (do_pop) begin
            if (s.sp == 5'h00) begin
                // fetch level: next instruction's entry, or idle while decode finishes
                seq_next = idle_step_request ? mss_pkg::IDLE_ADDR : dec_next;
            end else begin
                seq_sp = 5'(s.sp - 5'h01);
                seq_next = s.stack[seq_sp[3:0]];
            end
        end

        // trap replaces the address with the vector, high bits zero, and saves the address it displaced
        if (trap_request) begin
            push_val = seq_next;
            seq_next = {9'h000, trap_from_storage, trap_vector};
            do_push = 1'b1;
        end

        // ------------------------------------------------------------
        // beat sequencing
        // ------------------------------------------------------------
        if (s.clr_sync) begin
            next_s.nar = mss_pkg::START_ADDR;
            next_s.phase = mss_pkg::PH_ADDR;
            next_s.have_word = 1'b0;
            next_s.sp = 5'h00;
        end else begin
            case (s.phase)
                mss_pkg::PH_ADDR: begin
                    next_s.phase = mss_pkg::PH_READ;
                    if (!s.have_word) begin
                        next_s.nar = mss_pkg::START_ADDR;
                    end else if (s.repeat_pending) begin
                        // once after power-on, so traps stay off until microcode cleans up
                        next_s.nar = mss_pkg::START_ADDR;
                        next_s.repeat_pending = 1'b0;
                    end else begin
                        next_s.nar = seq_next;
                        next_s.rtf = do_pop && (s.sp == 5'h00);
                        if (do_push && (seq_sp != mss_pkg::STACK_FULL)) begin
                            next_s.stack[seq_sp[3:0]] = push_val;
                            next_s.sp = 5'(seq_sp + 5'h01);
                            next_s.swp = 1'b1;
                        end else begin
                            next_s.sp = seq_sp;
                        end
                    end
                end
                default: begin
                    next_s.phase = mss_pkg::PH_ADDR;
                    next_s.cword = store[s.nar];
                    next_s.have_word = 1'b1;
                    if (bus_load_high) begin
                        next_s.nar[13:8] = data_bus_high[5:0];
                        next_s.hcnt = mss_pkg::LOAD_BEAT_CYCLES;
                    end
                    if (bus_load_low) begin
                        next_s.nar[7:0] = data_bus_high;
                        next_s.lcnt = mss_pkg::LOAD_BEAT_CYCLES;
                    end
                end
            endcase
        end

        // ------------------------------------------------------------
        // register bus: write; any master gets identical treatment
        // ------------------------------------------------------------
        if (s_axi_awvalid && s_axi_awready) begin
            next_s.aw_held = 1'b1;
            next_s.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_s.w_held = 1'b1;
            next_s.wdata = s_axi_wdata;
            next_s.wstrb = s_axi_wstrb;
        end
        if (s.aw_held && s.w_held) begin
            next_s.aw_held = 1'b0;
            next_s.w_held = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = mss_pkg::RESP_OKAY;
            if (s.awaddr == mss_pkg::OFF_ADDR_HIGH) begin
                if (s.wstrb[0]) begin
                    next_s.load_addr[13:8] = s.wdata[5:0];
                end
                next_s.byte_idx = 4'h0;
            end else if (s.awaddr == mss_pkg::OFF_ADDR_LOW) begin
                if (s.wstrb[0]) begin
                    next_s.load_addr[7:0] = s.wdata[7:0];
                end
                next_s.byte_idx = 4'h0;
            end else if (s.awaddr == mss_pkg::OFF_DATA) begin
                if (s.wstrb[0]) begin
                    if (s.byte_idx == mss_pkg::LAST_BYTE) begin
                        // whole word only: partial fields never reach the store
                        mem_we = 1'b1;
                        next_s.byte_idx = 4'h0;
                    end else begin
                        next_s.assembly = {s.assembly[63:0], s.wdata[7:0]};
                        next_s.byte_idx = 4'(s.byte_idx + 4'h1);
                    end
                end
            end else if (s.awaddr != mss_pkg::OFF_STATUS) begin
                next_s.bresp = mss_pkg::RESP_SLVERR;
            end
        end
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end

        // ------------------------------------------------------------
        // register bus: read
        // ------------------------------------------------------------
        if (s_axi_arvalid && s_axi_arready) begin
            next_s.rvalid = 1'b1;
            next_s.rresp = mss_pkg::RESP_OKAY;
            next_s.rdata = 32'h0000_0000;
            if (s_axi_araddr == mss_pkg::OFF_ADDR_HIGH) begin
                next_s.rdata[5:0] = s.load_addr[13:8];
            end else if (s_axi_araddr == mss_pkg::OFF_ADDR_LOW) begin
                next_s.rdata[7:0] = s.load_addr[7:0];
            end else if (s_axi_araddr == mss_pkg::OFF_DATA) begin
                next_s.rdata[7:0] = rd_byte;
                next_s.byte_idx = (s.byte_idx == mss_pkg::LAST_BYTE) ? 4'h0 : 4'(s.byte_idx + 4'h1);
            end else if (s_axi_araddr == mss_pkg::OFF_STATUS) begin
                next_s.rdata[13:0] = s.nar;
                next_s.rdata[14] = (s.sp == 5'h00);
                next_s.rdata[15] = s.clr_sync;
                next_s.rdata[20:16] = s.sp;
            end else begin
                next_s.rresp = mss_pkg::RESP_SLVERR;
            end
        end
        if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
            s.clr_meta <= mss_pkg::RST_CLEAR;
            s.clr_sync <= mss_pkg::RST_CLEAR;
            s.phase <= mss_pkg::PH_ADDR;
            s.repeat_pending <= mss_pkg::RST_REPEAT;
            s.nar <= mss_pkg::START_ADDR;
        end else if (clock_enable) begin
            s <= next_s;
            if (mem_we) begin
                store[s.load_addr] <= mem_wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign s_axi_awready = !s.aw_held && !s.bvalid;
    assign s_axi_wready = !s.w_held && !s.bvalid;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_arready = !s.rvalid;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;
    assign control_word = s.cword;
    assign microword_address = s.nar;
    assign stage5_address_clock = !s.clr_sync && (s.phase == mss_pkg::PH_ADDR);
    assign late_control_word_clock = !s.clr_sync && (s.phase == mss_pkg::PH_READ);
    assign stack_empty_flag = (s.sp == 5'h00);
    assign return_to_fetch = s.rtf;
    assign stack_write_pulse = s.swp;
    assign high_half_load_clock = (s.hcnt != 2'h0);
    assign low_half_load_clock = (s.lcnt != 2'h0);

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    AST_CLEAR_HOLD: assert property (
        @(posedge aclk) disable iff (!aresetn)
        clock_enable && s.clr_sync |=> s.nar == mss_pkg::START_ADDR)
        else $error("address not held at start during clear");

    AST_REPEAT_FIRST: assert property (
        @(posedge aclk) disable iff (!aresetn)
        stage5 && s.have_word && s.repeat_pending |=> s.nar == mss_pkg::START_ADDR ##1 !s.repeat_pending)
        else $error("first word not repeated");

    AST_GOTO: assert property (
        @(posedge aclk) disable iff (!aresetn)
        stage5 && seq_normal && !trap_request && op == mss_pkg::OP_SPLIT && sub == mss_pkg::SUB_GOTO
        |=> s.nar == $past(goto_next))
        else $error("goto address wrong");

    AST_FLIP: assert property (
        @(posedge aclk) disable iff (!aresetn)
        stage5 && seq_normal && !trap_request && op == mss_pkg::OP_FLIP
        |=> s.nar == ($past(s.nar) ^ mss_pkg::BIT12_MASK))
        else $error("flip step address wrong");

    AST_JUMP: assert property (
        @(posedge aclk) disable iff (!aresetn)
        stage5 && seq_normal && !trap_request && op == mss_pkg::OP_JUMP
        |=> s.nar[3:0] == $past(jump_address_bits) && s.nar[13:6] == $past(s.nar[13:6]))
        else $error("jump address wrong");

    AST_PUSH_PULSE: assert property (
        @(posedge aclk) disable iff (!aresetn)
        stage5 && seq_normal && !do_pop && (trap_request || op == mss_pkg::OP_PUSH) && s.sp < 5'h0f
        |=> stack_write_pulse && s.sp == 5'($past(s.sp) + 5'h01))
        else $error("stack write pulse missing");

    AST_FETCH_RETURN: assert property (
        @(posedge aclk) disable iff (!aresetn)
        stage5 && seq_normal && !trap_request && op == mss_pkg::OP_RETURN && stack_empty_flag
        |=> return_to_fetch && stack_empty_flag)
        else $error("return to fetch not signalled");

    AST_IDLE_STEP: assert property (
        @(posedge aclk) disable iff (!aresetn)
        stage5 && seq_normal && !trap_request && op == mss_pkg::OP_RETURN && stack_empty_flag && idle_step_request
        |=> s.nar == mss_pkg::IDLE_ADDR)
        else $error("idle step not taken");

    AST_TRAP_VECTOR: assert property (
        @(posedge aclk) disable iff (!aresetn)
        stage5 && seq_normal && trap_request
        |=> s.nar == {9'h000, $past(trap_from_storage), $past(trap_vector)})
        else $error("trap vector wrong");

    COV_FETCH_RETURN: cover property (@(posedge aclk) disable iff (!aresetn) return_to_fetch);
    COV_TRAP: cover property (@(posedge aclk) disable iff (!aresetn) stage5 && seq_normal && trap_request);
    COV_WORD_WRITE: cover property (@(posedge aclk) disable iff (!aresetn) clock_enable && mem_we);
    COV_REPEAT: cover property (@(posedge aclk) disable iff (!aresetn) stage5 && s.have_word && s.repeat_pending);

endmodule : mss_sequencer

`default_nettype wire

// [tb/mss_loader.sv]
`default_nettype none
// axi4-lite master standing in for the diagnostic loader
module mss_loader (
    // clock
    input wire logic aclk,
    // slave answers
    input wire logic awready,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic [1:0] bresp,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, lrd;
    logic [1:0] lrr;
    logic [79:0] lword;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    int hang = 0;
    // we high writes, low reads; one idle edge at the end so no valid is driven twice at one edge
    task automatic xs(input logic we, input logic [7:0] a, input logic [31:0] d);
        logic aok = 1'h0, wok = !we, bok = 1'h0;
        {awaddr, wdata, araddr} <= {a, d, a};
        {awvalid, wvalid, bready, arvalid, rready} <= {we, we, we, !we, !we};
        for (int i = 0; i < 64 && !bok; i++) begin
            // answers move on the rising edge, so read them settled at the falling one
            @(negedge aclk);
            aok |= we ? awready : arready;
            wok |= wready;
            bok = we ? bvalid : rvalid;
            {lrd, lrr} = {rdata, we ? bresp : rresp};
            @(posedge aclk);
            {awvalid, wvalid, bready} <= {we & !aok, we & !wok, we & !bok};
            {arvalid, rready} <= {!we & !aok, !we & !bok};
        end
        hang += int'(!bok);
        @(posedge aclk);
    endtask : xs
    // address bytes first, then all ten data bytes high first: a partial word never exists
    task automatic ld(input logic rdb, input logic [13:0] a, input logic [79:0] w);
        xs(1'h1, mss_pkg::OFF_ADDR_HIGH, {26'h0, a[13:8]});
        xs(1'h1, mss_pkg::OFF_ADDR_LOW, {24'h0, a[7:0]});
        for (int k = 0; k < 10; k++) begin
            xs(!rdb, mss_pkg::OFF_DATA, {24'h0, w[79 - 8 * k -: 8]});
            lword[79 - 8 * k -: 8] = lrd[7:0];
        end
    endtask : ld
endmodule : mss_loader
`default_nettype wire

// [tb/mss_sequencer_tb.sv]
`default_nettype none
module mss_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'h0, aresetn = 1'h0, clr_n = 1'h0;
    logic [40:0] sq = 41'h0;
    logic awr, wrd, bv, arr, rv, s5, rtf, sef, swp;
    logic [79:0] cw;
    logic [1:0] br, rr;
    logic [31:0] rdat;
    logic [13:0] ma;
    int n, n_errors = 0, tests_run = 0;
    always #4 aclk = ~aclk;
    mss_loader u_mss_loader (.aclk(aclk), .awready(awr), .wready(wrd), .bvalid(bv), .bresp(br), .arready(arr),
        .rvalid(rv), .rdata(rdat), .rresp(rr));
    mss_sequencer u_mss_sequencer (.aclk(aclk), .aresetn(aresetn), .clock_enable(1'h1),
        .s_axi_awaddr(u_mss_loader.awaddr), .s_axi_awvalid(u_mss_loader.awvalid), .s_axi_awready(awr),
        .s_axi_wdata(u_mss_loader.wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(u_mss_loader.wvalid),
        .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(u_mss_loader.bready),
        .s_axi_araddr(u_mss_loader.araddr), .s_axi_arvalid(u_mss_loader.arvalid), .s_axi_arready(arr),
        .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(u_mss_loader.rready),
        .system_clear_n(clr_n), .jump_address_bits(sq[3:0]), .conditional_return_true(sq[4]),
        .decode_address(sq[18:5]), .effective_address_select(sq[19]), .effective_address_bits(sq[23:20]),
        .data_bus_high(sq[31:24]), .bus_load_high(sq[32]), .bus_load_low(sq[33]), .idle_step_request(sq[34]),
        .trap_request(sq[35]), .trap_from_storage(sq[36]), .trap_vector(sq[40:37]), .control_word(cw),
        .microword_address(ma), .stage5_address_clock(s5), .late_control_word_clock(), .stack_empty_flag(sef),
        .return_to_fetch(rtf), .stack_write_pulse(swp), .high_half_load_clock(), .low_half_load_clock());
    function automatic logic [79:0] mkw(input logic [2:0] op, input logic [15:0] cu);
        return {31'h0, cu, 1'h0, op, 29'h0};
    endfunction : mkw
    task automatic chk(input logic [79:0] g, input logic [79:0] e);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %0t got %h want %h", $time, g, e);
        end
    endtask : chk
    task automatic conclude;
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : conclude
    // counts address beats seen before the wanted address lands; a miss ends the run
    task automatic wt(input logic [13:0] a, output int c);
        c = 0;
        for (int i = 0; i < 40 && ma !== a; i++) begin
            @(negedge aclk);
            c += int'(s5 === 1'h1);
        end
        chk(ma, a);
        if (ma !== a) conclude();
    endtask : wt
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        u_mss_loader.ld(1'h0, 14'h0080, mkw(mss_pkg::OP_SPLIT, {mss_pkg::SUB_GOTO, 14'h0123}));
        chk(u_mss_loader.lrr, mss_pkg::RESP_OKAY);
        u_mss_loader.ld(1'h0, 14'h0123, mkw(mss_pkg::OP_PUSH, 16'h0));
        u_mss_loader.ld(1'h0, 14'h0133, mkw(mss_pkg::OP_RETURN, 16'h0));
        u_mss_loader.ld(1'h0, 14'h0103, mkw(mss_pkg::OP_RETURN, 16'h0));
        u_mss_loader.ld(1'h0, 14'h0000, mkw(mss_pkg::OP_JUMP, 16'h4000));
        u_mss_loader.ld(1'h0, 14'h0015, mkw(mss_pkg::OP_FLIP, 16'h0));
        u_mss_loader.ld(1'h0, 14'h0005, mkw(mss_pkg::OP_RETURN, 16'h0));
        u_mss_loader.ld(1'h0, mss_pkg::IDLE_ADDR, mkw(mss_pkg::OP_FLIP, 16'h0));
        u_mss_loader.ld(1'h0, 14'h3fff, 80'h0123456789abcdef5aa5);
        u_mss_loader.ld(1'h1, 14'h3fff, 80'h0);
        chk(u_mss_loader.lword, 80'h0123456789abcdef5aa5);
        u_mss_loader.xs(1'h0, mss_pkg::OFF_STATUS, 32'h0);
        chk(u_mss_loader.lrd[20:0], 21'h00c080);
        u_mss_loader.xs(1'h0, 8'h10, 32'h0);
        chk(u_mss_loader.lrr, mss_pkg::RESP_SLVERR);
        u_mss_loader.xs(1'h1, 8'h10, 32'h0);
        chk(u_mss_loader.lrr, mss_pkg::RESP_SLVERR);
        chk(u_mss_loader.hang, 0);
        $display("test load done");
        clr_n <= 1'h1;
        wt(14'h0123, n);
        chk(n, 3);
        wt(14'h0133, n);
        chk(swp, 1'h1);
        wt(14'h0103, n);
        chk(sef, 1'h1);
        for (int i = 0; i < 20 && rtf !== 1'h1; i++) @(negedge aclk);
        chk(rtf, 1'h1);
        @(posedge aclk);
        sq[34] <= 1'h1;
        sq[3:0] <= 4'h5;
        wt(14'h0015, n);
        chk(cw, mkw(mss_pkg::OP_JUMP, 16'h4000));
        wt(14'h0005, n);
        wt(mss_pkg::IDLE_ADDR, n);
        @(posedge aclk);
        sq[40:35] <= 6'h0f;
        wt(14'h0013, n);
        chk(sef, 1'h0);
        $display("test sequence done");
        conclude();
    end
endmodule : mss_sequencer_tb
`default_nettype wire
